// *** core/ctrb_top.sv ***
// Purpose : core trim register bank with apb access and fuse default loading
// Assumes : fuse storage answers each request with a one-cycle ack and data
// Notes   : bus stalls while the fuse defaults are being fetched
//           refused accesses answer with zero read data and drop writes
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

module ctrb_top
   import ctrb_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   fuse_req,
   output logic      [2:0]        fuse_sel,
   input  wire logic [15:0]       fuse_rdata,
   input  wire logic              fuse_ack,
   output logic      [TIME_W-1:0] core_a_time_trim,
   output logic                   core_a_time_vld,
   output logic      [TIME_W-1:0] core_b_time_trim,
   output logic                   core_b_time_vld,
   output logic      [OFS_W-1:0]  core_a_ofs_trim,
   output logic                   core_a_ofs_vld
);
   import ctrb_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   // storage and control
   logic [15:0]       trim_ff [NUM_TRIMS];
   logic [2:0]        ctrl_ff;
   logic [31:0]       prdata_ff;
   logic              fg_en;
   logic              dual_mode;
   logic              inb_sel;

   // fuse loader
   ctrb_fuse_e        fstate_ff;
   ctrb_fuse_e        nxt_fstate;
   logic [2:0]        fsel_ff;
   logic [2:0]        nxt_fsel;
   logic              freq_ff;
   logic              fuse_take;
   logic              load_done;
   logic              loading;

   // bus decode
   logic              busy;
   logic              rd_prep;
   logic              wr_stb;
   logic [9:0]        idx;
   logic [2:0]        wr_slot;
   logic [2:0]        rd_slot;
   logic              reload;
   logic              refused;
   logic              ctrl_wr;
   logic              trim_wr;
   logic [31:0]       rd_word;

   // routed trims and their flops
   logic [TIME_W-1:0] r_a_time;
   logic              r_a_time_vld;
   logic [TIME_W-1:0] r_b_time;
   logic              r_b_time_vld;
   logic [OFS_W-1:0]  r_a_ofs;
   logic              r_a_ofs_vld;
   logic [TIME_W-1:0] a_time_ff;
   logic              a_time_vld_ff;
   logic [TIME_W-1:0] b_time_ff;
   logic              b_time_vld_ff;
   logic [OFS_W-1:0]  a_ofs_ff;
   logic              a_ofs_vld_ff;

   // ************************************************************
   // bus slave
   // ************************************************************

   // handshake and decode
   ctrb_apb_slave u_apb (
      .clk     (clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .busy    (busy),
      .pready  (pready),
      .pslverr (pslverr),
      .rd_prep (rd_prep),
      .wr_stb  (wr_stb),
      .idx     (idx)
   );

   // slot decode for write and read
   assign wr_slot = ctrb_slot_of(idx);
   assign rd_slot = ctrb_slot_of(idx);
   assign busy    = (fstate_ff != FS_DONE);

   // write strobes per destination
   assign ctrl_wr = wr_stb && (idx == IDX_CTRL);
   assign trim_wr = wr_stb && (wr_slot != SLOT_NONE);
   assign reload  = ctrl_wr && pwdata[CTRL_RELOAD_BIT];

   // refused accesses answer with zero read data
   assign refused = (paddr[1:0] != 2'h0) || !ctrb_mapped(idx);

   // ************************************************************
   // fuse default loader
   // ************************************************************

   // walk all slots, one request per slot
   always_comb begin
      nxt_fstate = fstate_ff;
      nxt_fsel   = fsel_ff;
      case (fstate_ff)
         FS_BOOT: begin
            nxt_fstate = FS_REQ;
            nxt_fsel   = SLOT_A_INA;
         end
         FS_REQ: begin
            if (fuse_ack) begin
               if (fsel_ff == SLOT_LAST) begin
                  nxt_fstate = FS_DONE;
               end else begin
                  nxt_fsel = fsel_ff + 3'h1;
               end
            end
         end
         FS_DONE: begin
            if (reload) begin
               nxt_fstate = FS_REQ;
               nxt_fsel   = SLOT_A_INA;
            end
         end
         default: begin
            nxt_fstate = FS_BOOT;
            nxt_fsel   = SLOT_A_INA;
         end
      endcase
   end

   // loader state and slot pointer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fstate_ff <= FS_BOOT;
         fsel_ff   <= SLOT_A_INA;
      end else if (ce) begin
         fstate_ff <= nxt_fstate;
         fsel_ff   <= nxt_fsel;
      end
   end

   // request level, registered so the fuse side sees a clean pin
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         freq_ff <= 1'b0;
      end else if (ce) begin
         freq_ff <= (nxt_fstate == FS_REQ);
      end
   end

   // a fuse word is taken only while a request stands
   assign fuse_take = (fstate_ff == FS_REQ) && fuse_ack;
   assign fuse_req  = freq_ff;
   assign fuse_sel  = fsel_ff;

   // ************************************************************
   // trim storage
   // ************************************************************

   // fuse data loads defaults, bus writes overwrite them
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_TRIMS; i++) begin
            trim_ff[i] <= TRIM_RST;
         end
      end else if (ce) begin
         if (fuse_take) begin
            trim_ff[fsel_ff] <= fuse_rdata & ctrb_mask_of(fsel_ff);
         end else if (trim_wr) begin
            // spare bits 15:12 of offset trims are kept as written
            trim_ff[wr_slot] <= pwdata[15:0] & ctrb_mask_of(wr_slot);
         end
      end
   end

   // ************************************************************
   // control register
   // ************************************************************

   // mode, input selection and calibration enable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff <= CTRL_RST;
      end else if (ce) begin
         if (ctrl_wr) begin
            ctrl_ff <= pwdata[2:0];
         end
      end
   end

   // named control fields and loader status
   assign fg_en     = ctrl_ff[CTRL_FG_BIT];
   assign dual_mode = ctrl_ff[CTRL_DUAL_BIT];
   assign inb_sel   = ctrl_ff[CTRL_INB_BIT];
   assign load_done = (fstate_ff == FS_DONE);
   assign loading   = (fstate_ff == FS_REQ);

   // ************************************************************
   // read path
   // ************************************************************

   // assemble the read word for the addressed register
   always_comb begin
      rd_word = '0;
      if (rd_slot != SLOT_NONE) begin
         rd_word[15:0] = trim_ff[rd_slot];
      end else if (idx == IDX_CTRL) begin
         rd_word[2:0] = ctrl_ff;
      end else if (idx == IDX_STAT) begin
         rd_word[STAT_DONE_BIT] = load_done;
         rd_word[STAT_A_T_BIT]  = a_time_vld_ff;
         rd_word[STAT_B_T_BIT]  = b_time_vld_ff;
         rd_word[STAT_OFS_BIT]  = a_ofs_vld_ff;
         rd_word[STAT_LOAD_BIT] = loading;
      end
   end

   // capture read data with the cycle that raises pready
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_ff <= '0;
      end else if (ce) begin
         if (rd_prep && (!pwrite || refused)) begin
            prdata_ff <= refused ? 32'h0 : rd_word;
         end
      end
   end

   // read data pin
   assign prdata = prdata_ff;

   // ************************************************************
   // trim routing to the cores
   // ************************************************************

   // condition selection
   ctrb_trim_route u_route (
      .fg_en      (fg_en),
      .dual       (dual_mode),
      .inb        (inb_sel),
      .trim       (trim_ff),
      .a_time     (r_a_time),
      .a_time_vld (r_a_time_vld),
      .b_time     (r_b_time),
      .b_time_vld (r_b_time_vld),
      .a_ofs      (r_a_ofs),
      .a_ofs_vld  (r_a_ofs_vld)
   );

   // core a timing trim towards its core
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         a_time_ff     <= '0;
         a_time_vld_ff <= 1'b0;
      end else if (ce) begin
         a_time_ff     <= r_a_time;
         a_time_vld_ff <= r_a_time_vld;
      end
   end

   // core b timing trim towards its core
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         b_time_ff     <= '0;
         b_time_vld_ff <= 1'b0;
      end else if (ce) begin
         b_time_ff     <= r_b_time;
         b_time_vld_ff <= r_b_time_vld;
      end
   end

   // core a offset trim towards its core
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         a_ofs_ff      <= '0;
         a_ofs_vld_ff  <= 1'b0;
      end else if (ce) begin
         a_ofs_ff      <= r_a_ofs;
         a_ofs_vld_ff  <= r_a_ofs_vld;
      end
   end

   // core-facing pins straight from their flops
   assign core_a_time_trim = a_time_ff;
   assign core_a_time_vld  = a_time_vld_ff;
   assign core_b_time_trim = b_time_ff;
   assign core_b_time_vld  = b_time_vld_ff;
   assign core_a_ofs_trim  = a_ofs_ff;
   assign core_a_ofs_vld   = a_ofs_vld_ff;

endmodule

// *** core/ctrb_pkg.sv ***
// Purpose : shared constants, types and decode functions of the core trim register bank
// Assumes : apb with 32-bit data; every register takes one aligned word
// Notes   : printed offsets are word indices, byte address is four times the index
//
// How it works
// - core a single-channel input a timing trim, 8 bits read/write at index 0x314, reset 0.
// - core b single-channel input a timing trim, 8 bits read/write at index 0x315, reset 0.
// - core a single-channel input b timing trim, 8 bits read/write at index 0x31a, reset 0.
// - core b single-channel input b timing trim, 8 bits read/write at index 0x31b, reset 0.
// - core a dual-channel input a offset trim in bits 11:0 at 0x344, bits 15:12 spare rw.
// - core a dual-channel input b offset trim in bits 11:0 at 0x346, bits 15:12 spare rw.
// - every trim takes its default from fuse storage, readable and overwritable afterwards.
// - timing trims are driven to both cores, in single-channel mode with fg_en set, to shift their sampling instant.

package ctrb_pkg;

   // ************************************************************
   // address map (word indices)
   // ************************************************************
   localparam logic [9:0]  IDX_A_SGL_INA_TIME = 10'h314;
   localparam logic [9:0]  IDX_B_SGL_INA_TIME = 10'h315;
   localparam logic [9:0]  IDX_A_SGL_INB_TIME = 10'h31a;
   localparam logic [9:0]  IDX_B_SGL_INB_TIME = 10'h31b;
   localparam logic [9:0]  IDX_A_DUAL_INA_OFS = 10'h344;
   localparam logic [9:0]  IDX_A_DUAL_INB_OFS = 10'h346;
   localparam logic [9:0]  IDX_CTRL           = 10'h300;
   localparam logic [9:0]  IDX_STAT           = 10'h301;

   // ************************************************************
   // trim slots, widths and reset values
   // ************************************************************
   localparam int          NUM_TRIMS   = 6;
   localparam logic [2:0]  SLOT_A_INA  = 3'h0;
   localparam logic [2:0]  SLOT_B_INA  = 3'h1;
   localparam logic [2:0]  SLOT_A_INB  = 3'h2;
   localparam logic [2:0]  SLOT_B_INB  = 3'h3;
   localparam logic [2:0]  SLOT_OFS_A  = 3'h4;
   localparam logic [2:0]  SLOT_OFS_B  = 3'h5;
   localparam logic [2:0]  SLOT_LAST   = 3'h5;
   localparam logic [2:0]  SLOT_NONE   = 3'h7;
   localparam logic [15:0] TIME_MASK   = 16'h00ff;
   localparam logic [15:0] OFS_MASK    = 16'hffff;
   localparam logic [15:0] TRIM_RST    = 16'h0000;
   localparam int          TIME_W      = 8;
   localparam int          OFS_W       = 12;

   // ************************************************************
   // control and status fields
   // ************************************************************
   localparam int          CTRL_FG_BIT     = 0;
   localparam int          CTRL_DUAL_BIT   = 1;
   localparam int          CTRL_INB_BIT    = 2;
   localparam int          CTRL_RELOAD_BIT = 3;
   localparam logic [2:0]  CTRL_RST        = 3'h0;
   localparam int          STAT_DONE_BIT   = 0;
   localparam int          STAT_A_T_BIT    = 1;
   localparam int          STAT_B_T_BIT    = 2;
   localparam int          STAT_OFS_BIT    = 3;
   localparam int          STAT_LOAD_BIT   = 4;

   // fuse loader states
   typedef enum logic [1:0] {FS_BOOT, FS_REQ, FS_DONE} ctrb_fuse_e;

   // word index to trim slot
   function automatic logic [2:0] ctrb_slot_of(input logic [9:0] idx);
      case (idx)
         IDX_A_SGL_INA_TIME: ctrb_slot_of = SLOT_A_INA;
         IDX_B_SGL_INA_TIME: ctrb_slot_of = SLOT_B_INA;
         IDX_A_SGL_INB_TIME: ctrb_slot_of = SLOT_A_INB;
         IDX_B_SGL_INB_TIME: ctrb_slot_of = SLOT_B_INB;
         IDX_A_DUAL_INA_OFS: ctrb_slot_of = SLOT_OFS_A;
         IDX_A_DUAL_INB_OFS: ctrb_slot_of = SLOT_OFS_B;
         default:            ctrb_slot_of = SLOT_NONE;
      endcase
   endfunction

   // implemented bits of a slot
   function automatic logic [15:0] ctrb_mask_of(input logic [2:0] slot);
      ctrb_mask_of = (slot < SLOT_OFS_A) ? TIME_MASK : OFS_MASK;
   endfunction

   // index answers on the bus
   function automatic logic ctrb_mapped(input logic [9:0] idx);
      ctrb_mapped = (ctrb_slot_of(idx) != SLOT_NONE) || (idx == IDX_CTRL) || (idx == IDX_STAT);
   endfunction

endpackage

// *** core/ctrb_apb_slave.sv ***
// Purpose : apb handshake for the trim bank, one wait state, stall while busy
// Assumes : master keeps the request stable until pready is seen
// Notes   : writes take effect on the edge where pready is sampled high
`timescale 1ns/1ps

module ctrb_apb_slave
   import ctrb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic        busy,
   output logic             pready,
   output logic             pslverr,
   output logic             rd_prep,
   output logic             wr_stb,
   output logic [9:0]       idx
);
   logic pready_ff;
   logic pslverr_ff;
   logic bad;

   // ************************************************************
   // decode
   // ************************************************************
   assign idx     = paddr[11:2];
   assign bad     = (paddr[1:0] != 2'h0) || !ctrb_mapped(paddr[11:2]);
   assign rd_prep = psel && penable && !pready_ff && !busy; // answer in next cycle
   assign wr_stb  = psel && penable && pready_ff && pwrite && !pslverr_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ready and error stand one cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         pready_ff  <= rd_prep;
         pslverr_ff <= rd_prep && bad;
      end
   end

endmodule

// *** core/ctrb_trim_route.sv ***
// Purpose : selects which trim reaches each core in the current mode
// Assumes : mode bits are stable static configuration
// Notes   : purely combinational; the top registers the results
`timescale 1ns/1ps

module ctrb_trim_route
   import ctrb_pkg::*;
(
   input  wire logic              fg_en,
   input  wire logic              dual,
   input  wire logic              inb,
   input  wire logic [15:0]       trim [NUM_TRIMS],
   output logic      [TIME_W-1:0] a_time,
   output logic                   a_time_vld,
   output logic      [TIME_W-1:0] b_time,
   output logic                   b_time_vld,
   output logic      [OFS_W-1:0]  a_ofs,
   output logic                   a_ofs_vld
);
   logic sgl_on;
   logic dual_on;

   assign sgl_on  = fg_en && !dual;
   assign dual_on = fg_en && dual;

   // pick trim by input selection, zero where no condition holds
   always_comb begin
      a_time     = '0;
      b_time     = '0;
      a_ofs      = '0;
      a_time_vld = sgl_on;
      b_time_vld = sgl_on;
      a_ofs_vld  = dual_on;
      if (sgl_on) begin
         a_time = inb ? trim[SLOT_A_INB][TIME_W-1:0] : trim[SLOT_A_INA][TIME_W-1:0];
         b_time = inb ? trim[SLOT_B_INB][TIME_W-1:0] : trim[SLOT_B_INA][TIME_W-1:0];
      end
      if (dual_on) begin
         a_ofs = inb ? trim[SLOT_OFS_B][OFS_W-1:0] : trim[SLOT_OFS_A][OFS_W-1:0];
      end
   end

endmodule

// *** dv/ctrb_top_props.sv ***
// Purpose : port checks of the trim bank
// Assumes : one clock, reset async active low
// Notes   : bound to every ctrb_top
`timescale 1ns/1ps

module ctrb_top_props
   import ctrb_pkg::*;
(
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fuse_req,
   input wire logic [2:0]  fuse_sel,
   input wire logic        fuse_ack,
   input wire logic [7:0]  core_a_time_trim,
   input wire logic        core_a_time_vld,
   input wire logic [7:0]  core_b_time_trim,
   input wire logic        core_b_time_vld,
   input wire logic [11:0] core_a_ofs_trim,
   input wire logic        core_a_ofs_vld
);
   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_ready_pulse: assert property (pready && ce |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_unalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   a_err_rdzero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("refused access without zero data");
   a_fuse_step: assert property (fuse_req && fuse_ack && ce && fuse_sel < 3'h5 |=>
      fuse_req && fuse_sel == $past(fuse_sel) + 3'h1)
      else $error("fuse slot did not advance");
   a_fuse_last: assert property (fuse_req && fuse_ack && ce && fuse_sel == 3'h5 |=> !fuse_req)
      else $error("fuse request held after last slot");
   a_fuse_hold: assert property (fuse_req && !fuse_ack && ce |=> fuse_req && $stable(fuse_sel))
      else $error("fuse request dropped before ack");
   a_load_stall: assert property (fuse_req |-> !pready)
      else $error("bus answered during fuse load");
   a_time_idle: assert property (!core_a_time_vld |->
      core_a_time_trim == 8'h0 && core_b_time_trim == 8'h0)
      else $error("timing trim leaks while invalid");
   a_mode_excl: assert property (core_a_time_vld |-> core_b_time_vld && !core_a_ofs_vld)
      else $error("timing and offset valid together");
   a_ofs_idle: assert property (!core_a_ofs_vld |-> core_a_ofs_trim == 12'h0)
      else $error("offset trim leaks while invalid");

   c_refused: cover property (pready && pslverr);
   c_load_end: cover property (fuse_ack && fuse_sel == 3'h5);
   c_time: cover property (core_a_time_vld);
   c_ofs: cover property (core_a_ofs_vld);
endmodule

bind ctrb_top ctrb_top_props u_props (.clk, .arst_n, .ce, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .fuse_req, .fuse_sel, .fuse_ack, .core_a_time_trim, .core_a_time_vld,
   .core_b_time_trim, .core_b_time_vld, .core_a_ofs_trim, .core_a_ofs_vld);

// *** dv/ctrb_top_tb.sv ***
// Purpose : self-checking bench of the trim bank
// Assumes : bench answers fuse requests with random delay
// Notes   : model keeps expected trims from fuse data and writes
`timescale 1ns/1ps

module ctrb_top_tb;
   import ctrb_pkg::*;
   logic        clk, arst_n, ce, psel, penable, pwrite, fuse_ack;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, fuse_req, er;
   logic [2:0]  fuse_sel;
   logic [15:0] fuse_rdata, fd, fw;
   logic [7:0]  at, bt;
   logic [11:0] ot;
   logic        av, bv, ov;
   int          miscompares, samples_checked, cyc, fcnt;
   integer      seed = 32'h1e0a32a6;
   logic [15:0] exp_trim [6];
   logic [15:0] fuse_exp [6];
   logic [9:0]  idx_tab [6] = '{IDX_A_SGL_INA_TIME, IDX_B_SGL_INA_TIME, IDX_A_SGL_INB_TIME,
                                IDX_B_SGL_INB_TIME, IDX_A_DUAL_INA_OFS, IDX_A_DUAL_INB_OFS};
   localparam logic [11:0] CTRL_A = {IDX_CTRL, 2'h0};

   ctrb_top uut (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fuse_req, .fuse_sel, .fuse_rdata, .fuse_ack,
      .core_a_time_trim(at), .core_a_time_vld(av), .core_b_time_trim(bt),
      .core_b_time_vld(bv), .core_a_ofs_trim(ot), .core_a_ofs_vld(ov));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] msk(input int s);
      msk = (s < 4) ? TIME_MASK : OFS_MASK;
   endfunction

   // expected core outputs for ctrl bits {inb, dual, fg}
   function automatic logic [31:0] core_exp(input logic [2:0] m);
      logic vt, vo;
      int   sa;
      vt = m[0] & ~m[1];
      vo = m[0] & m[1];
      sa = m[2] ? 2 : 0;
      core_exp = {1'b0, vt, vt ? exp_trim[sa][7:0] : 8'h0, vt, vt ? exp_trim[sa+1][7:0] : 8'h0,
                  vo, vo ? exp_trim[m[2] ? 5 : 4][11:0] : 12'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task tally_and_finish;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // one apb transfer, held until pready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, q);
      chk("pslverr", {31'h0, ee}, {31'h0, er});
   endtask

   // ************************************************************
   // clock, timeout and fuse storage
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish;
      end
   end

   // fuse answers after a random delay, data inverted while idle
   always @(posedge clk) begin
      if (!arst_n) begin
         fuse_ack <= 1'b0;
         fuse_rdata <= 16'h0;
      end else if (fuse_ack) begin
         fuse_ack <= 1'b0;
         fuse_rdata <= ~fuse_rdata;
      end else if (fuse_req === 1'b1 && fcnt < 6 && $random(seed) % 2 == 0) begin
         fw = 16'($random(seed));
         chk("fuse_sel", 32'(fcnt), {29'h0, fuse_sel});
         fuse_exp[fcnt] = fw & msk(fcnt);
         fcnt++;
         fuse_ack <= 1'b1;
         fuse_rdata <= fw;
      end else begin
         fuse_rdata <= ~fuse_rdata;
         if (fuse_req !== 1'b1) begin
            fcnt = 0;
         end
      end
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      // first access stalls until defaults are loaded
      rd_chk(CTRL_A, 32'h0, 1'b0);
      exp_trim = fuse_exp;
      for (int s = 0; s < 6; s++) begin
         rd_chk({idx_tab[s], 2'h0}, {16'h0, exp_trim[s]}, 1'b0);
      end
      // overwrite with random data, spare offset bits kept
      for (int s = 0; s < 6; s++) begin
         fd = 16'($random(seed));
         apb(1'b1, {idx_tab[s], 2'h0}, {16'($random(seed)), fd});
         exp_trim[s] = fd & msk(s);
         rd_chk({idx_tab[s], 2'h0}, {16'h0, exp_trim[s]}, 1'b0);
      end
      // unmapped and unaligned accesses are refused, no write lands
      apb(1'b1, 12'h000, 32'hffff);
      chk("pslverr", 32'h1, {31'h0, er});
      apb(1'b1, {idx_tab[0], 2'h2}, 32'h5a);
      chk("pslverr", 32'h1, {31'h0, er});
      rd_chk({idx_tab[1], 2'h1}, 32'h0, 1'b1);
      rd_chk({idx_tab[0], 2'h0}, {16'h0, exp_trim[0]}, 1'b0);
      // clock enable low freezes the handshake mid-transfer
      fork
         rd_chk({idx_tab[2], 2'h0}, {16'h0, exp_trim[2]}, 1'b0);
         begin
            @(posedge clk);
            ce <= 1'b0;
            repeat (3) @(posedge clk);
            chk("pready", 32'h0, {31'h0, pready});
            @(posedge clk);
            ce <= 1'b1;
         end
      join
      // every mode and input combination
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, CTRL_A, 32'(m));
         repeat (3) @(posedge clk);
         chk("core", core_exp(m[2:0]), {1'b0, av, at, bv, bt, ov, ot});
         rd_chk(CTRL_A, 32'(m), 1'b0);
         rd_chk({IDX_STAT, 2'h0}, {28'h0, m[0] & m[1], {2{m[0] & ~m[1]}}, 1'b1}, 1'b0);
      end
      // reload restores fuse defaults over written values
      apb(1'b1, CTRL_A, 32'h8);
      rd_chk(CTRL_A, 32'h0, 1'b0);
      exp_trim = fuse_exp;
      for (int s = 0; s < 6; s++) begin
         rd_chk({idx_tab[s], 2'h0}, {16'h0, exp_trim[s]}, 1'b0);
      end
      tally_and_finish;
   end
endmodule
